// ===== tb_two_pin_general_io.sv
// Self-checking bench for the two-pin general I/O block over AXI4-Lite.
// Assumes the design's assertions stand in its own files.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_two_pin_general_io;
	import tpgio_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, pin_i, pin_o, pin_oe, lvl;
	int errors, cmp_count;
	tpgio_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_pin_i(pin_i),
		.aux_pin_o(pin_o), .aux_pin_oe(pin_oe));
	tpgio_board board (.pin_o(pin_o), .pin_oe(pin_oe), .drive_lvl(lvl), .pin_i(pin_i));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task close_out;
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// Handshakes are judged on values settled before the edge, so no race with the design's flops
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		n = 0;
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awready & awvalid; tw = wready & wvalid; tb = bvalid; r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end while (tb !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50) begin
			errors++;
			close_out();
		end
		`CHK(r, er)
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ta, tv;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arready & arvalid; tv = rvalid; d = rdata; r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end while (tv !== 1'b1 && n < 50);
		rready <= 1'b0;
		if (n >= 50) begin
			errors++;
			close_out();
		end
		`CHK(d, ed)
		`CHK(r, er)
	endtask : rd
	initial begin
		errors = 0; cmp_count = 0; aresetn = 1'b0; lvl = 2'h3;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(4'h0, 32'h0f, 2'h0);
		`CHK(pin_oe, 2'h0)
		lvl <= 2'h1;
		rd(4'h0, 32'h07, 2'h0);
		wr(4'h0, 32'h03, 4'hf, 2'h0);
		rd(4'h0, 32'h07, 2'h0);
		wr(4'h0, 32'h01, 4'hf, 2'h0);
		`CHK({pin_oe, pin_o[1]}, 3'h5)
		rd(4'h0, 32'h0d, 2'h0);
		wr(4'h0, 32'hf1, 4'hf, 2'h0);
		`CHK(pin_o[1], 1'b0)
		rd(4'h0, 32'h05, 2'h0);
		wr(4'h0, 32'h0f, 4'h0, 2'h0);
		rd(4'h0, 32'h05, 2'h0);
		wr(4'h0, 32'h00, 4'hf, 2'h0);
		`CHK({pin_oe, pin_o}, 4'hd)
		rd(4'h0, 32'h04, 2'h0);
		wr(4'h0, 32'h00, 4'hf, 2'h0);
		`CHK(pin_o, 2'h0)
		rd(4'h0, 32'h00, 2'h0);
		wr(4'h0, 32'h0c, 4'hf, 2'h0);
		`CHK(pin_o, 2'h3)
		wr(4'h4, 32'h03, 4'hf, 2'h3);
		rd(4'h4, 32'h00, 2'h3);
		rd(4'h0, 32'h0c, 2'h0);
		close_out();
	end
endmodule : tb_two_pin_general_io

// ===== tpgio_board.sv
// Board-side model of the two general pins.
// Assumes the testbench picks the level the board puts on pins the block leaves undriven.
`timescale 1ns/100ps
module tpgio_board (
	input wire logic [1:0] pin_o,
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] drive_lvl,
	output logic [1:0] pin_i
);
	// A pin the block drives reads its own level; otherwise the board's level wins
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & drive_lvl);
endmodule : tpgio_board

// ===== tpgio_map.svh
// Register map constants for the two-pin general I/O block.
// Assumes inclusion by name from the package and the design file.
`ifndef TPGIO_MAP_SVH
`define TPGIO_MAP_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define TPGIO_PIN_CTRL_ADDR 4'h0
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPGIO_DIR_ZERO_BIT 0
`define TPGIO_DIR_ONE_BIT 1
`define TPGIO_VAL0_BIT 2
`define TPGIO_VAL1_BIT 3
// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define TPGIO_DIR_RESET 1'b1
`define TPGIO_VAL_RESET 1'b1
`define TPGIO_RESP_OKAY 2'b00
`define TPGIO_RESP_DECERR 2'b11
`endif

// ===== tpgio_pkg.sv
// Types for the two-pin general I/O block.
// Assumes the map header is on the include path.
package tpgio_pkg;
	`include "tpgio_map.svh"
	typedef enum logic [1:0] {
		TPGIO_W_IDLE = 2'b01,
		TPGIO_W_RESP = 2'b10
	} tpgio_wstate_t;
	typedef struct packed {
		logic [1:0] dir;
		logic [1:0] val;
	} tpgio_ctrl_t;
	typedef struct packed {
		logic [1:0] o;
		logic [1:0] oe;
	} tpgio_pins_t;
	typedef struct packed {
		tpgio_wstate_t wst;
		logic aw_seen;
		logic [3:0] awaddr;
		logic w_seen;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		tpgio_ctrl_t ctrl;
		tpgio_pins_t pins;
	} tpgio_state_t;
endpackage : tpgio_pkg

// ===== tpgio_top.sv
// Two general-purpose pins under one 8-bit control register on AXI4-Lite.
// Assumes pin inputs synchronous to aclk; the pad ring resolves o/oe into wires.
// Contract
// R1: With pin one an output, it drives the level in bit 3, which is readable and writable.
// R2: After reset pin one's level bit holds 1.
// R3: With pin one an input, bit 3 is read-only and reads the sampled pin level.
// R4: With pin zero an output, it drives the level in bit 2, which is readable and writable.
// R5: Bit 1 selects pin one as output at 0 and input at 1, input after reset.
// R6: With pin zero an input, bit 2 is read-only and reads the sampled pin level.
// R7: Bit 0 selects pin zero direction like bit 1, and writes to bits 7 to 4 do nothing.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "tpgio_map.svh"
module tpgio_top
	import tpgio_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] aux_pin_i,
	output logic [1:0] aux_pin_o,
	output logic [1:0] aux_pin_oe
);
	tpgio_state_t st;
	tpgio_state_t next_st;
	logic [7:0] reg_view;
	logic aw_hs;
	logic w_hs;
	logic [1:0] val_wr;
	logic [1:0] dir_wr;

	// ----------------------------------------------------------------
	// Register view
	// ----------------------------------------------------------------
	// An input pin reads its live level; an output reads the stored bit.
	always_comb begin
		reg_view = 8'h00;
		reg_view[`TPGIO_DIR_ZERO_BIT] = st.ctrl.dir[0];
		reg_view[`TPGIO_DIR_ONE_BIT] = st.ctrl.dir[1];
		reg_view[`TPGIO_VAL0_BIT] = st.ctrl.dir[0] ? aux_pin_i[0] : st.ctrl.val[0]; // [R6] [R4]
		reg_view[`TPGIO_VAL1_BIT] = st.ctrl.dir[1] ? aux_pin_i[1] : st.ctrl.val[1]; // [R3] [R1]
	end

	assign s_axi_awready = (st.wst == TPGIO_W_IDLE) && !st.aw_seen;
	assign s_axi_wready = (st.wst == TPGIO_W_IDLE) && !st.w_seen;
	assign s_axi_bvalid = (st.wst == TPGIO_W_RESP);
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign aux_pin_o = st.pins.o;
	assign aux_pin_oe = st.pins.oe;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		val_wr = 2'b00;
		dir_wr = 2'b00;
		if (aw_hs) begin
			next_st.aw_seen = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			next_st.w_seen = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		case (st.wst)
			TPGIO_W_IDLE: begin
				if (st.aw_seen && st.w_seen) begin
					next_st.aw_seen = 1'b0;
					next_st.w_seen = 1'b0;
					next_st.wst = TPGIO_W_RESP;
					if ({st.awaddr[3:2], 2'b00} == `TPGIO_PIN_CTRL_ADDR) begin
						next_st.bresp = `TPGIO_RESP_OKAY;
						// Only the low lane holds the register; bits 7..4 are dropped
						if (st.wstrb[0]) begin
							dir_wr = st.wdata[`TPGIO_DIR_ONE_BIT:`TPGIO_DIR_ZERO_BIT]; // [R5] [R7]
							val_wr = st.wdata[`TPGIO_VAL1_BIT:`TPGIO_VAL0_BIT];
							next_st.ctrl.dir = dir_wr;
							// An input pin's level bit is read-only: keep the stored value
							for (int i = 0; i < 2; i++) begin
								if (!st.ctrl.dir[i]) begin
									next_st.ctrl.val[i] = val_wr[i]; // [R1] [R4] [R3] [R6]
								end
							end
						end
					end else begin
						next_st.bresp = `TPGIO_RESP_DECERR;
					end
				end
			end
			TPGIO_W_RESP: begin
				if (s_axi_bready) begin
					next_st.wst = TPGIO_W_IDLE;
				end
			end
			default: begin
				next_st.wst = TPGIO_W_IDLE;
			end
		endcase
		if (st.rvalid) begin
			if (s_axi_rready) begin
				next_st.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			next_st.rvalid = 1'b1;
			if ({s_axi_araddr[3:2], 2'b00} == `TPGIO_PIN_CTRL_ADDR) begin
				next_st.rdata = {24'h000000, reg_view};
				next_st.rresp = `TPGIO_RESP_OKAY;
			end else begin
				next_st.rdata = 32'h00000000;
				next_st.rresp = `TPGIO_RESP_DECERR;
			end
		end
		// Pin drive is registered from the next register value, so it changes on the same edge as the register
		next_st.pins.oe = ~next_st.ctrl.dir; // [R5] [R7]
		next_st.pins.o = next_st.ctrl.val; // [R1] [R4]
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.wst <= TPGIO_W_IDLE;
			st.aw_seen <= 1'b0;
			st.awaddr <= 4'h0;
			st.w_seen <= 1'b0;
			st.wdata <= 32'h00000000;
			st.wstrb <= 4'h0;
			st.bresp <= `TPGIO_RESP_OKAY;
			st.rvalid <= 1'b0;
			st.rdata <= 32'h00000000;
			st.rresp <= `TPGIO_RESP_OKAY;
			st.ctrl.dir <= {2{`TPGIO_DIR_RESET}}; // [R5] [R7]
			st.ctrl.val <= {2{`TPGIO_VAL_RESET}}; // [R2]
			st.pins.o <= {2{`TPGIO_VAL_RESET}}; // [R2]
			st.pins.oe <= 2'b00;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_wr_out1;
		st.wst == TPGIO_W_IDLE && st.aw_seen && st.w_seen && st.awaddr[3:2] == 2'b00
			&& st.wstrb[0] && !st.ctrl.dir[1] && !st.wdata[1];
	endsequence

	a_pin_one_drive: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		s_wr_out1 |=> ##1 (aux_pin_oe[1] && aux_pin_o[1] == $past(st.wdata[3], 2)))
		else $error("pin one does not drive written level");
	a_reset_level_one: assert property (@(posedge aclk) // [R2]
		!aresetn |=> (st.ctrl.val[1] && aux_pin_o[1] && !aux_pin_oe[1]))
		else $error("pin one level bit not 1 after reset");
	a_pin_one_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b00 && st.ctrl.dir[1])
			|=> (s_axi_rvalid && s_axi_rdata[3] == $past(aux_pin_i[1])))
		else $error("pin one input level misread");
	a_pin_zero_drive: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		!st.ctrl.dir[0] |-> (aux_pin_oe[0] && aux_pin_o[0] == st.ctrl.val[0]))
		else $error("pin zero drive mismatch");
	a_dir_one_oe: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		$changed(st.ctrl.dir[1]) |=> aux_pin_oe[1] == !$past(st.ctrl.dir[1]))
		else $error("pin one enable does not follow direction");
	a_pin_zero_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		(st.ctrl.dir[0] && $past(st.ctrl.dir[0])) |-> st.ctrl.val[0] == $past(st.ctrl.val[0]))
		else $error("input level bit changed by write");
	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000)
		else $error("reserved bits read nonzero");
	a_resp_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.aw_seen && st.w_seen && st.wst == TPGIO_W_IDLE) |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
		else $error("write response not raised");

	// ----------------------------------------------------------------
	// Reset and pin drive
	// ----------------------------------------------------------------
	// Both pins come up as inputs so nothing fights the board at power-up
	a_dir_one_reset: assert property (@(posedge aclk) // [R5]
		!aresetn |=> (st.ctrl.dir[1] && !aux_pin_oe[1]))
		else $error("pin one not input after reset");
	a_dir_zero_reset: assert property (@(posedge aclk) // [R7]
		!aresetn |=> (st.ctrl.dir[0] && !aux_pin_oe[0]))
		else $error("pin zero not input after reset");

	for (genvar gi = 0; gi < 2; gi++) begin : g_pin_chk
		a_oe_follows_dir: assert property (@(posedge aclk) disable iff (!aresetn) // [R5] [R7]
			aux_pin_oe[gi] == !st.ctrl.dir[gi])
			else $error("pin enable differs from direction bit");
		a_o_follows_val: assert property (@(posedge aclk) disable iff (!aresetn) // [R1] [R4]
			!st.ctrl.dir[gi] |-> aux_pin_o[gi] == st.ctrl.val[gi])
			else $error("output pin level differs from level bit");
		a_out_readback: assert property (@(posedge aclk) disable iff (!aresetn) // [R1] [R4]
			(s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b00 && !st.ctrl.dir[gi])
				|=> s_axi_rdata[2 + gi] == $past(st.ctrl.val[gi]))
			else $error("output level bit not read back");
	end

	// ----------------------------------------------------------------
	// Read-only level bits and ignored writes
	// ----------------------------------------------------------------
	sequence s_wr_done;
		st.wst == TPGIO_W_IDLE && st.aw_seen && st.w_seen;
	endsequence

	a_pin_zero_sample: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b00 && st.ctrl.dir[0])
			|=> (s_axi_rvalid && s_axi_rdata[2] == $past(aux_pin_i[0])))
		else $error("pin zero input level misread");
	a_pin_one_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(st.ctrl.dir[1] && $past(st.ctrl.dir[1])) |-> st.ctrl.val[1] == $past(st.ctrl.val[1]))
		else $error("pin one input level bit changed by write");
	a_strb_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		(s_wr_done ##0 !st.wstrb[0]) |=> $stable(st.ctrl))
		else $error("write without low lane changed register");
	a_decerr_nowrite: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_wr_done ##0 st.awaddr[3:2] != 2'b00)
			|=> ($stable(st.ctrl) && s_axi_bresp == `TPGIO_RESP_DECERR))
		else $error("unmapped write not refused");

	// ----------------------------------------------------------------
	// Bus handshakes
	// ----------------------------------------------------------------
	// A response must hold still until the master takes it
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
		else $error("read response dropped early");
	a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write taken while response pending");
	a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while response pending");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read response not raised");
endmodule : tpgio_top
